/* File: hw/sgdc_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sgdc_consts.svh"
module sgdc_top
  import sgdc_pkg::*;
#(
  parameter int WIDTH = `SGDC_WORD_BITS
) (
  // System clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Serial link
  input  wire logic             clk_link,
  input  wire logic             serial_in,
  output var  logic             serial_out,
  // Control pins, with undriven flags standing for the pull-ups
  input  wire logic             latch_enable,
  input  wire logic             le_undriven,
  input  wire logic             blank_n,
  input  wire logic             blank_undriven,
  // Register port
  input  wire logic [3:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output var  logic [7:0]       reg_rdata,
  // Gate lines and switch paths
  output var  sgdc_gate_t       gate_r,
  output var  sgdc_path_t       path_r
);
  generate
    if (WIDTH != `SGDC_WORD_BITS) begin : g_bad
      $error("sgdc_top supports only an eight-bit word");
    end
  endgenerate

  localparam int NSYNC = 5;

  logic [WIDTH-1:0] link_word;
  logic             link_toggle;
  logic [NSYNC-1:0] pins_async;
  logic [NSYNC-1:0] pins_sync;
  logic             s_le;
  logic             s_le_und;
  logic             s_bl;
  logic             s_bl_und;
  logic             s_tog;
  logic             le_eff;
  logic             blank_eff;
  logic             tog_seen_r;
  logic             new_word;
  logic [WIDTH-1:0] shadow_r;
  logic             shadow_ok_r;
  logic [WIDTH-1:0] latch_r;
  logic             latch_ok_r;
  logic             soft_blank_r;
  sgdc_gate_t       gate_nxt;
  sgdc_path_t       path_nxt;
  logic [7:0]       rdata_nxt;
  logic [7:0]       status;
  sgdc_req_t        req;

  // Link-domain shift register and chain output
  sgdc_link_shift #(
    .WIDTH       (WIDTH)
  ) u_shift (
    .clk_link    (clk_link),
    .resetn      (resetn),
    .serial_in   (serial_in),
    .serial_out  (serial_out),
    .word        (link_word),
    .edge_toggle (link_toggle)
  );

  assign pins_async = {link_toggle, blank_undriven, blank_n, le_undriven, latch_enable};

  sgdc_sync #(
    .WIDTH    (NSYNC)
  ) u_sync (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .async_in (pins_async),
    .sync_out (pins_sync)
  );

  assign s_le     = pins_sync[0];
  assign s_le_und = pins_sync[1];
  assign s_bl     = pins_sync[2];
  assign s_bl_und = pins_sync[3];
  assign s_tog    = pins_sync[4];

  // Pull-ups: an undriven pin reads high
  assign le_eff    = s_le | s_le_und;
  assign blank_eff = s_bl | s_bl_und;

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  // Word crossing: the link word is stable for a whole link period after a toggle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tog_seen_r <= 1'b0;
    end else begin
      tog_seen_r <= s_tog;
    end
  end

  assign new_word = s_tog ^ tog_seen_r;

  // Copy of the shift register, no reset
  always_ff @(posedge clk_sys) begin
    if (new_word) begin
      shadow_r <= link_word;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadow_ok_r <= 1'b0;
    end else if (new_word) begin
      shadow_ok_r <= 1'b1;
    end
  end

  // Level-sensitive latch, transparent while latch enable is high
  always_ff @(posedge clk_sys) begin
    if (le_eff && shadow_ok_r) begin
      latch_r <= shadow_r;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      latch_ok_r <= 1'b0;
    end else if (le_eff && shadow_ok_r) begin
      latch_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      soft_blank_r <= `SGDC_CTRL_RESET;
    end else if (req.wr && req.addr == `SGDC_OFS_CTRL) begin
      soft_blank_r <= req.wdata[`SGDC_CTRL_BLANK];
    end
  end

  // Gate mapping; positions 4 to 7 are not looked at
  always_comb begin
    gate_nxt = '0;
    if (blank_eff && !soft_blank_r && latch_ok_r) begin
      gate_nxt.gate_line_one   = latch_r[`SGDC_POS_ONE];
      gate_nxt.gate_line_two   = latch_r[`SGDC_POS_TWO];
      gate_nxt.gate_line_three = latch_r[`SGDC_POS_THREE];
      gate_nxt.gate_line_eight = latch_r[`SGDC_POS_EIGHT];
    end
  end

  always_comb begin
    path_nxt.a_to_single_out_one = gate_nxt.gate_line_one;
    path_nxt.pair_one_closed     = gate_nxt.gate_line_two;
    path_nxt.pair_two_closed     = gate_nxt.gate_line_three;
    path_nxt.b_to_single_out_two = gate_nxt.gate_line_eight;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gate_r <= '0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      path_r <= '0;
    end else begin
      path_r <= path_nxt;
    end
  end

  // Register reads
  always_comb begin
    status                     = 8'h00;
    status[`SGDC_ST_LE]        = le_eff;
    status[`SGDC_ST_BLANK]     = blank_eff;
    status[`SGDC_ST_LOADED]    = latch_ok_r;
    status[`SGDC_ST_GATE0 +: 4] = gate_r;
  end

  always_comb begin
    rdata_nxt = 8'h00;
    if (req.rd) begin
      unique case (req.addr)
        `SGDC_OFS_CTRL:   rdata_nxt = {7'h00, soft_blank_r};
        `SGDC_OFS_LATCH:  rdata_nxt = latch_ok_r ? latch_r : 8'h00;
        `SGDC_OFS_SHIFT:  rdata_nxt = shadow_ok_r ? shadow_r : 8'h00;
        `SGDC_OFS_STATUS: rdata_nxt = status;
        default:          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence drive_on;
    blank_eff && !soft_blank_r && latch_ok_r;
  endsequence

  sequence word_while_open;
    new_word && le_eff && shadow_ok_r ##1 le_eff;
  endsequence

  sequence pin_blanked;
    !blank_n && !blank_undriven;
  endsequence

  blank_forces_off_a: assert property (
    !blank_eff |=> gate_r == '0 && path_r == '0)
    else $error("gates not off while blanked");

  gate_select_a: assert property (
    drive_on |=> gate_r == {$past(latch_r[7]), $past(latch_r[2:0])})
    else $error("gate lines do not match latched bits 1 2 3 8");

  unused_bits_a: assert property (
    $stable(latch_r[2:0]) && $stable(latch_r[7]) && $stable(latch_ok_r)
      && $stable(blank_eff) && $stable(soft_blank_r) |=> $stable(gate_r))
    else $error("unused latch bits changed a gate");

  level_drive_a: assert property (
    gate_r.gate_line_eight |-> $past(latch_r[`SGDC_POS_EIGHT]) && $past(blank_eff))
    else $error("gate eight high without a latched one");

  latch_pass_a: assert property (
    le_eff && shadow_ok_r |=> latch_r == $past(shadow_r))
    else $error("latch not transparent while enabled");

  transparent_shift_a: assert property (
    word_while_open |=> latch_r == $past(shadow_r) ##1 1'b1)
    else $error("latch did not follow a new word");

  latch_hold_a: assert property (
    !le_eff && latch_ok_r |=> $stable(latch_r))
    else $error("latch changed with enable low");

  shadow_hold_a: assert property (
    shadow_ok_r && latch_ok_r && !new_word |=> $stable(shadow_r))
    else $error("shift copy changed without a shift");

  pullup_le_a: assert property (
    s_le_und && shadow_ok_r |=> latch_r == $past(shadow_r))
    else $error("undriven latch enable did not read high");

  pullup_blank_a: assert property (
    s_bl_und && !soft_blank_r && latch_ok_r |=> gate_r.gate_line_one == $past(latch_r[0]))
    else $error("undriven blanking did not read high");

  path_map_a: assert property (
    path_r == {gate_r.gate_line_eight, gate_r.gate_line_three,
               gate_r.gate_line_two, gate_r.gate_line_one})
    else $error("switch paths disagree with gate lines");

  read_timing_a: assert property (
    reg_rd && reg_addr == `SGDC_OFS_CTRL |=> reg_rdata == {7'h00, soft_blank_r})
    else $error("control read wrong");

  pin_blank_a: assert property (
    pin_blanked |=> ##2 gate_r == '0 && path_r == '0)
    else $error("blanking pin did not turn the gates off");

  soft_blank_a: assert property (
    soft_blank_r |=> gate_r == '0)
    else $error("gates not off while blanked by control bit");

  gate_hold_a: assert property (
    !$past(le_eff) && $stable(blank_eff) && $stable(soft_blank_r) && $stable(latch_ok_r)
      |=> $stable(gate_r))
    else $error("gates changed with latch enable low");

  status_read_a: assert property (
    reg_rd && reg_addr == `SGDC_OFS_STATUS
      |=> reg_rdata[`SGDC_ST_GATE0 +: 4] == $past(gate_r))
    else $error("status read shows wrong gate lines");

  read_idle_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared after the read cycle");

  loaded_keep_a: assert property (
    latch_ok_r |=> latch_ok_r)
    else $error("loaded flag cleared without reset");

  unloaded_off_a: assert property (
    !latch_ok_r |=> gate_r == '0)
    else $error("gates driven before the latch was loaded");
endmodule
`default_nettype wire

/* File: hw/sgdc_consts.svh */
// Behaviour
// - Each rising edge of the link clock shifts one serial input bit into an eight-stage shift register.
// - While latch enable is high, the shift register word passes through the eight-bit latch to the gates.
// - Latch enable held high while shifting keeps the latch transparent, so gates follow every edge.
// - Only latched positions 1, 2, 3 and 8 drive gate lines one, two, three and eight.
// - Latched positions 4 to 7 affect no switch but still occupy shift stages.
// - A latched one drives its gate line to the high bias level (closed); a zero leaves it off (open).
// - The last shift stage is brought out on the serial output so devices can be chained.
// - Shift register and latch have no reset; they change only when new data is shifted in and latched.
//   Here reset turns the gates off and the latch reads 00 until the next shifted word is latched.
// - Blanking low forces every gate off whatever the data; blanking high lets the latch drive the gates.
// - Blanking and latch enable read high when left undriven, so a loose blanking pin means normal running.
// - With latch enable low and no clock edge, shift register and gates keep their state.
// - Gate one closes input A to single output one, two closes pair one, three pair two, eight input B to single output two.
`ifndef SGDC_CONSTS_SVH
`define SGDC_CONSTS_SVH

`define SGDC_WORD_BITS   8
`define SGDC_POS_ONE     0
`define SGDC_POS_TWO     1
`define SGDC_POS_THREE   2
`define SGDC_POS_EIGHT   7
`define SGDC_SYNC_STAGES 2

`define SGDC_ADDR_BITS   4
`define SGDC_DATA_BITS   8
`define SGDC_OFS_CTRL    4'h0
`define SGDC_OFS_LATCH   4'h1
`define SGDC_OFS_SHIFT   4'h2
`define SGDC_OFS_STATUS  4'h3

`define SGDC_CTRL_BLANK  0
`define SGDC_ST_LE       0
`define SGDC_ST_BLANK    1
`define SGDC_ST_LOADED   2
`define SGDC_ST_GATE0    4
`define SGDC_CTRL_RESET  1'b0

`endif

/* File: hw/sgdc_pkg.sv */
package sgdc_pkg;

  typedef struct packed {
    logic gate_line_eight;
    logic gate_line_three;
    logic gate_line_two;
    logic gate_line_one;
  } sgdc_gate_t;

  typedef struct packed {
    logic b_to_single_out_two;
    logic pair_two_closed;
    logic pair_one_closed;
    logic a_to_single_out_one;
  } sgdc_path_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } sgdc_req_t;

endpackage

/* File: hw/sgdc_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module sgdc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  generate
    if (WIDTH < 1) begin : g_bad
      $error("sgdc_sync width must be at least one");
    end
  endgenerate

  logic [WIDTH-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          meta_r[i]   <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* File: hw/sgdc_link_shift.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sgdc_consts.svh"
module sgdc_link_shift
  import sgdc_pkg::*;
#(
  parameter int WIDTH = `SGDC_WORD_BITS
) (
  // Link side
  input  wire logic             clk_link,
  input  wire logic             resetn,
  input  wire logic             serial_in,
  output var  logic             serial_out,
  // Toward the system domain
  output var  logic [WIDTH-1:0] word,
  output var  logic             edge_toggle
);
  generate
    if (WIDTH < `SGDC_WORD_BITS) begin : g_bad
      $error("sgdc_link_shift needs at least eight stages");
    end
  endgenerate

  logic [WIDTH-1:0] shift_r;
  logic [3:0]       edges_r;

  // No reset on the stages; contents come only from shifting
  always_ff @(posedge clk_link) begin
    shift_r <= {shift_r[WIDTH-2:0], serial_in};
  end

  // Last stage out, changes just after the rising edge
  always_ff @(posedge clk_link) begin
    serial_out <= shift_r[WIDTH-2];
  end

  // Flips once per shift so the system side sees each new word
  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      edge_toggle <= 1'b0;
    end else begin
      edge_toggle <= ~edge_toggle;
    end
  end

  always_ff @(posedge clk_link or negedge resetn) begin
    if (!resetn) begin
      edges_r <= 4'h0;
    end else if (edges_r != 4'hF) begin
      edges_r <= edges_r + 4'h1;
    end
  end

  assign word = shift_r;

  shift_in_a: assert property (@(posedge clk_link)
    edges_r >= 4'h9 |-> shift_r[0] == $past(serial_in) && shift_r[WIDTH-1:1] == $past(shift_r[WIDTH-2:0]))
    else $error("shift register did not take one bit");

  chain_out_a: assert property (@(posedge clk_link) disable iff (!resetn)
    edges_r >= 4'h9 |-> serial_out == $past(serial_in, WIDTH))
    else $error("serial output is not the input delayed eight edges");

  stage_out_a: assert property (@(posedge clk_link)
    edges_r >= 4'h8 |-> serial_out == shift_r[WIDTH-1])
    else $error("serial output does not match the last stage");
endmodule
`default_nettype wire

/* File: tb/sgdc_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module sgdc_ctl_model (
  // Link pins toward the device
  output var logic clk_link,
  output var logic serial_in,
  output var logic latch_enable
);
  initial begin
    clk_link     = 1'b0;
    serial_in    = 1'b0;
    latch_enable = 1'b0;
  end

  // Mode 0 shifts only, 1 latches after the frame, 2 keeps the latch open
  task automatic send(input logic [7:0] b, input int mode);
    if (mode == 2) begin
      latch_enable = 1'b1;
    end
    for (int k = 7; k >= 0; k--) begin
      serial_in = b[k];
      #15 clk_link = 1'b1;
      #15 clk_link = 1'b0;
    end
    // Released data line shows the inverse, link clock stands still
    serial_in = ~serial_in;
    if (mode == 1) begin
      #30 latch_enable = 1'b1;
    end
    #100 latch_enable = 1'b0;
    #60;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sgdc_pkg::*;
;
  logic        clk_sys        = 1'b0;
  logic        resetn         = 1'b1;
  logic        le_undriven    = 1'b0;
  logic        blank_n        = 1'b1;
  logic        blank_undriven = 1'b0;
  logic [3:0]  reg_addr       = 4'h0;
  logic [7:0]  reg_wdata      = 8'h00;
  logic        reg_wr         = 1'b0;
  logic        reg_rd         = 1'b0;
  logic        clk_link;
  logic        serial_in;
  logic        serial_out;
  logic        latch_enable;
  logic [7:0]  reg_rdata;
  sgdc_gate_t  gate_r;
  sgdc_path_t  path_r;
  int          n_errors       = 0;
  int          check_count    = 0;
  logic [7:0]  d;
  logic [7:0]  b;
  logic [7:0]  last;
  int unsigned rnd;

  always #5 clk_sys = ~clk_sys;

  sgdc_ctl_model mdl (
    .clk_link     (clk_link),
    .serial_in    (serial_in),
    .latch_enable (latch_enable)
  );

  sgdc_top dut (
    .clk_sys        (clk_sys),
    .resetn         (resetn),
    .clk_link       (clk_link),
    .serial_in      (serial_in),
    .serial_out     (serial_out),
    .latch_enable   (latch_enable),
    .le_undriven    (le_undriven),
    .blank_n        (blank_n),
    .blank_undriven (blank_undriven),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .gate_r         (gate_r),
    .path_r         (path_r)
  );

  function automatic logic [7:0] gates_of(input logic [7:0] v);
    return {4'h0, v[7], v[2], v[1], v[0]};
  endfunction

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Bounded wait for the gates to settle on a value
  task automatic wait_gate(input logic [7:0] e);
    int i;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if ({4'h0, gate_r} === e) break;
    end
    check("gate", {4'h0, gate_r}, e);
    if (i == 40) begin
      end_sim();
    end
  endtask

  task automatic chk_load(input logic [7:0] v);
    wait_gate(gates_of(v));
    check("path", {4'h0, path_r}, gates_of(v));
    rd(4'h1, d);
    check("latch", d, v);
    rd(4'h2, d);
    check("shift", d, v);
    check("serial_out", {7'h00, serial_out}, {7'h00, v[7]});
    rd(4'h3, d);
    check("status_gates", {4'h0, d[7:4]}, gates_of(v));
  endtask

  initial begin
    resetn <= 1'b0;
    rnd = $urandom(32'h22B3613A);
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    check("gate_rst", {4'h0, gate_r}, 8'h00);
    rd(4'h0, d);
    check("ctrl_rst", d, 8'h00);
    wr(4'h5, 8'hFF);
    rd(4'h5, d);
    check("unmapped", d, 8'h00);
    rd(4'h0, d);
    check("ctrl_keep", d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      b = (i == 0) ? 8'h81 : (i == 1) ? 8'h78 : 8'($urandom);
      mdl.send(b, 1);
      chk_load(b);
    end
    last = b;
    mdl.send(~last, 0);
    repeat (12) @(posedge clk_sys);
    check("gate_hold", {4'h0, gate_r}, gates_of(last));
    rd(4'h2, d);
    check("shift_new", d, ~last);
    rd(4'h1, d);
    check("latch_hold", d, last);
    le_undriven <= 1'b1;
    wait_gate(gates_of(~last));
    le_undriven <= 1'b0;
    last = ~last;
    b = {1'b1, ~last[6:0]};
    mdl.send(b, 2);
    chk_load(b);
    @(posedge clk_sys);
    blank_n <= 1'b0;
    wait_gate(8'h00);
    blank_undriven <= 1'b1;
    wait_gate(gates_of(b));
    blank_undriven <= 1'b0;
    blank_n        <= 1'b1;
    wr(4'h0, 8'h01);
    wait_gate(8'h00);
    rd(4'h0, d);
    check("ctrl_set", d, 8'h01);
    wr(4'h0, 8'h00);
    wait_gate(gates_of(b));
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    check("latch_keep", dut.latch_r, b);
    rd(4'h1, d);
    check("latch_masked", d, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
